// [src/aamo_regs.vh]
// Purpose: constants for the accumulator add/and/move decode slice
// Assumes: 14-bit instruction word, 8-bit data, 7-bit file address
// Notes:   status flag positions follow the usual C/DC/Z layout
`ifndef AAMO_REGS_VH
`define AAMO_REGS_VH

// instruction word layout
`define AAMO_IW_W        14
`define AAMO_DW          8
`define AAMO_AW          7
`define AAMO_DEST_BIT    7

// opcode patterns on iw[13:8]
`define AAMO_OP_ADDL_MSK 6'h3e
`define AAMO_OP_ADDL     6'h3e
`define AAMO_OP_ANDL     6'h39
`define AAMO_OP_ADDF     6'h07
`define AAMO_OP_ANDF     6'h05
`define AAMO_OP_MOVE_REGISTER_TO_DESTINATION     6'h08
`define AAMO_OP_ZERO     6'h00

// status register bit positions and reset values
`define AAMO_ST_C        0
`define AAMO_ST_DC       1
`define AAMO_ST_Z        2
`define AAMO_ST_RST      8'h00
`define AAMO_ACC_RST     8'h00

// op codes passed to the alu
`define AAMO_ALU_ADD     2'h0
`define AAMO_ALU_AND     2'h1
`define AAMO_ALU_PASS    2'h2

`endif

// [src/aamo_alu.v]
// Purpose: 8-bit alu for add, and, pass
// Assumes: purely combinational, used by aamo_core
// Notes:   carry/half-carry only meaningful for add
`timescale 1ns/1ps
`include "aamo_regs.vh"

module aamo_alu
(
  // operands
  input  wire [7:0] acc_in,
  input  wire [7:0] opnd_in,
  input  wire [1:0] op_sel,
  // results
  output reg  [7:0] result,
  output reg        carry_out,
  output reg        half_carry_out
);

  reg [8:0] sum;
  reg [4:0] low_sum;

  // one adder serves both add forms
  always @*
  begin
    sum            = {1'b0, acc_in} + {1'b0, opnd_in};
    low_sum        = {1'b0, acc_in[3:0]} + {1'b0, opnd_in[3:0]};
    result         = opnd_in;
    carry_out      = sum[8];
    half_carry_out = low_sum[4];
    case (op_sel)
      `AAMO_ALU_ADD:  result = sum[7:0];
      `AAMO_ALU_AND:  result = acc_in & opnd_in;
      `AAMO_ALU_PASS: result = opnd_in;
      default:        result = opnd_in;
    endcase
  end

endmodule // aamo_alu

// [src/aamo_core.v]
// Purpose: decode and execute add/and/move/store/idle opcodes
// Assumes: file register read data is combinational on file_addr
// Notes:   fetch of next word overlaps execute of current one
`timescale 1ns/1ps
`include "aamo_regs.vh"

module aamo_core
#(
  parameter PC_W = 13
)
(
  // clock and reset
  input  wire                     clk,
  input  wire                     reset_n,
  input  wire                     clk_en,
  // program memory
  output reg  [PC_W-1:0]          prog_addr,
  input  wire [`AAMO_IW_W-1:0]    prog_data,
  // data register file
  output reg  [`AAMO_AW-1:0]      file_addr,
  input  wire [`AAMO_DW-1:0]      file_rdata,
  output reg  [`AAMO_DW-1:0]      file_wdata,
  output reg                      file_we,
  // architectural state
  output reg  [`AAMO_DW-1:0]      acc_out,
  output reg  [`AAMO_DW-1:0]      status_out,
  output reg                      illegal_op
);

  // opcode classes
  localparam [2:0] K_IDLE  = 3'h0;
  localparam [2:0] K_ADDL  = 3'h1;
  localparam [2:0] K_ANDL  = 3'h2;
  localparam [2:0] K_ADDF  = 3'h3;
  localparam [2:0] K_ANDF  = 3'h4;
  localparam [2:0] K_MOVE_REGISTER_TO_DESTINATION  = 3'h5;
  localparam [2:0] K_STOW  = 3'h6;
  localparam [2:0] K_OTHER = 3'h7;

  // decode used for execute only; the file address is taken straight from prog_data
  function [2:0] classify;
    input [`AAMO_IW_W-1:0] iw;
    begin
      if ((iw[13:8] & `AAMO_OP_ADDL_MSK) == `AAMO_OP_ADDL)
        classify = K_ADDL;
      else if (iw[13:8] == `AAMO_OP_ANDL)
        classify = K_ANDL;
      else if (iw[13:8] == `AAMO_OP_ADDF)
        classify = K_ADDF;
      else if (iw[13:8] == `AAMO_OP_ANDF)
        classify = K_ANDF;
      else if (iw[13:8] == `AAMO_OP_MOVE_REGISTER_TO_DESTINATION)
        classify = K_MOVE_REGISTER_TO_DESTINATION;
      else if (iw[13:8] == `AAMO_OP_ZERO && iw[7])
        classify = K_STOW;
      else if (iw[13:8] == `AAMO_OP_ZERO && iw[4:0] == 5'h00 && !iw[7])
        classify = K_IDLE;
      else
        classify = K_OTHER;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // pipeline: instruction register and fetch address
  reg  [`AAMO_IW_W-1:0] ir_q;
  reg  [PC_W-1:0]       pc_q;
  wire [2:0]            kind;
  wire                  dest_file;

  assign kind      = classify(ir_q);
  assign dest_file = ir_q[`AAMO_DEST_BIT];

  // fetch of next word runs alongside execute of ir_q
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_q <= {PC_W{1'b0}};
      ir_q <= {`AAMO_IW_W{1'b0}};   // idle word until first fetch lands
    end
    else if (clk_en)
    begin
      pc_q <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
      ir_q <= prog_data;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // execute: operand select and alu
  reg  [1:0] alu_sel;
  reg  [7:0] opnd;
  reg  [7:0] acc_q;
  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_dc;

  // literal forms take the low byte, file forms the read data
  always @*
  begin
    alu_sel = `AAMO_ALU_PASS;
    opnd    = file_rdata;
    case (kind)
      K_ADDL:
      begin
        alu_sel = `AAMO_ALU_ADD;
        opnd    = ir_q[7:0];
      end
      K_ANDL:
      begin
        alu_sel = `AAMO_ALU_AND;
        opnd    = ir_q[7:0];
      end
      K_ADDF:  alu_sel = `AAMO_ALU_ADD;
      K_ANDF:  alu_sel = `AAMO_ALU_AND;
      K_MOVE_REGISTER_TO_DESTINATION:  alu_sel = `AAMO_ALU_PASS;
      default: alu_sel = `AAMO_ALU_PASS;
    endcase
  end

  aamo_alu u_alu
  (
    .acc_in         (acc_q),
    .opnd_in        (opnd),
    .op_sel         (alu_sel),
    .result         (alu_res),
    .carry_out      (alu_c),
    .half_carry_out (alu_dc)
  );

  //////////////////////////////////////////////////////////////////////
  // architectural state: accumulator and status flags
  reg [7:0] acc_d;
  reg [7:0] status_q;
  reg [7:0] status_d;
  reg       wr_file;
  wire      zero;

  assign zero = (alu_res == 8'h00);

  // accumulator has no file address; only opcodes reach it
  always @*
  begin
    acc_d    = acc_q;
    status_d = status_q;
    wr_file  = 1'b0;
    case (kind)
      K_ADDL:
      begin
        acc_d                 = alu_res;
        status_d[`AAMO_ST_C]  = alu_c;
        status_d[`AAMO_ST_DC] = alu_dc;
        status_d[`AAMO_ST_Z]  = zero;
      end
      K_ADDF:
      begin
        if (dest_file)
          wr_file = 1'b1;
        else
          acc_d = alu_res;
        status_d[`AAMO_ST_C]  = alu_c;
        status_d[`AAMO_ST_DC] = alu_dc;
        status_d[`AAMO_ST_Z]  = zero;
      end
      K_ANDL:
      begin
        acc_d                = alu_res;
        status_d[`AAMO_ST_Z] = zero;
      end
      K_ANDF:
      begin
        if (dest_file)
          wr_file = 1'b1;
        else
          acc_d = alu_res;
        status_d[`AAMO_ST_Z] = zero;
      end
      K_MOVE_REGISTER_TO_DESTINATION:
      begin
        if (dest_file)
          wr_file = 1'b1;
        else
          acc_d = alu_res;
        status_d[`AAMO_ST_Z] = zero;
      end
      K_STOW:  wr_file = 1'b1;
      K_IDLE:  wr_file = 1'b0;
      default: wr_file = 1'b0;
    endcase
  end

  // state commits once per instruction cycle
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_q    <= `AAMO_ACC_RST;
      status_q <= `AAMO_ST_RST;
    end
    else if (clk_en)
    begin
      acc_q    <= acc_d;
      status_q <= status_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs, all registered
  // file strobe is registered, so write lands one cycle after execute;
  // file_rdata is read combinationally on the current ir_q address
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prog_addr  <= {PC_W{1'b0}};
      file_addr  <= {`AAMO_AW{1'b0}};
      file_wdata <= 8'h00;
      file_we    <= 1'b0;
      acc_out    <= `AAMO_ACC_RST;
      status_out <= `AAMO_ST_RST;
      illegal_op <= 1'b0;
    end
    else if (clk_en)
    begin
      prog_addr  <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
      file_addr  <= prog_data[6:0];        // address of next word's operand
      file_wdata <= (kind == K_STOW) ? acc_q : alu_res;
      file_we    <= wr_file;
      acc_out    <= acc_d;
      status_out <= status_d;
      illegal_op <= (kind == K_OTHER);     // unsupported opcodes act as idle
    end
  end

endmodule // aamo_core

// [test/aamo_core_asserts.sv]
// Purpose: port checker for aamo_core
// Assumes: clk_en high on both steps of a checked word
// Notes:   word taken at one edge, executed at the next
`timescale 1ns/1ps
module aamo_chk
#(
  parameter PC_W = 13
)
(
  // clock and reset
  input wire            clk,
  input wire            reset_n,
  input wire            clk_en,
  // program and file ports
  input wire [PC_W-1:0] prog_addr,
  input wire [13:0]     prog_data,
  input wire [7:0]      file_rdata,
  input wire [7:0]      file_wdata,
  input wire            file_we,
  // state
  input wire [7:0]      acc_out,
  input wire [7:0]      status_out
);
  wire [5:0] op = prog_data[13:8];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // word seen, then one more enabled step to execute it
  sequence go(c);
    clk_en && reset_n && c ##1 clk_en;
  endsequence
  addl_sum_a: assert property (go(op[5:1] == 5'h1f) |=>
    {status_out[0], acc_out} == {1'b0, $past(acc_out)} + $past(prog_data[7:0], 2))
    else $error("literal add wrong");
  addf_acc_a: assert property (go(op == 6'h07 && !prog_data[7]) |=>
    !file_we && acc_out == $past(acc_out) + $past(file_rdata)) else $error("file add wrong");
  andl_zero_a: assert property (go(op == 6'h39) |=> acc_out ==
    ($past(acc_out) & $past(prog_data[7:0], 2)) && status_out[2] == (acc_out == 8'h00)
    && status_out[1:0] == $past(status_out[1:0])) else $error("literal and wrong");
  andf_file_a: assert property (go(op == 6'h05 && prog_data[7]) |=> file_we
    && file_wdata == ($past(acc_out) & $past(file_rdata)) && $stable(acc_out))
    else $error("file and wrong");
  move_register_to_destination_back_a: assert property (go(op == 6'h08 && prog_data[7]) |=>
    file_we && file_wdata == $past(file_rdata)) else $error("move back wrong");
  move_register_to_destination_zero_a: assert property (go(op == 6'h08) |=>
    status_out[2] == ($past(file_rdata) == 8'h00) && $stable(status_out[1:0]))
    else $error("move zero wrong");
  store_keep_a: assert property (go(prog_data[13:7] == 7'h01) |=>
    file_we && file_wdata == acc_out && $stable(status_out)) else $error("store wrong");
  pc_step_a: assert property (reset_n && clk_en |=> prog_addr == $past(prog_addr) + 1'b1)
    else $error("fetch stalled");
  idle_quiet_a: assert property (go(prog_data[13:7] == 7'h00 && prog_data[4:0] == 5'h00)
    |=> !file_we && $stable(acc_out) && $stable(status_out)) else $error("idle changed");
  // main scenarios reached
  cover property (go(op == 6'h3f) ##1 status_out[0]);
  cover property (go(op == 6'h08 && prog_data[7]) ##1 file_we);
  cover property (go(op == 6'h07 && prog_data[7]) ##1 file_we);
endmodule // aamo_chk
bind aamo_core aamo_chk #(.PC_W(PC_W)) CHK (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
  .prog_addr(prog_addr), .prog_data(prog_data), .file_rdata(file_rdata),
  .file_wdata(file_wdata), .file_we(file_we), .acc_out(acc_out), .status_out(status_out));

// [test/aamo_fmem.sv]
// Purpose: data register file beside aamo_core
// Assumes: write strobe trails its word by one step
// Notes:   address latched, since file_addr has moved on by then
`timescale 1ns/1ps
module aamo_fmem
(
  // clock
  input wire       clk,
  input wire       clk_en,
  // file port
  input wire [6:0] file_addr,
  output wire[7:0] file_rdata,
  input wire [7:0] file_wdata,
  input wire       file_we
);
  reg [7:0] mem [0:127];
  reg [6:0] wa_q;
  integer   i;
  initial for (i = 0; i < 128; i = i + 1) mem[i] = 8'h00;
  // read follows the address with no delay
  assign file_rdata = mem[file_addr];
  // write goes to the executing word's address
  always @(posedge clk)
    if (clk_en)
    begin
      wa_q <= file_addr;
      if (file_we) mem[wa_q] <= file_wdata;
    end
endmodule // aamo_fmem

// [test/testbench.sv]
// Purpose: directed run of the add/and/move slice
// Assumes: fixed result latency of two enabled edges
// Notes:   each word sent by ex is followed by an idle word
`timescale 1ns/1ps
module testbench;
  reg         clk, reset_n, clk_en;
  reg  [13:0] prog_data;
  wire [12:0] prog_addr;
  wire [6:0]  file_addr;
  wire [7:0]  file_rdata, file_wdata, acc_out, status_out;
  wire        file_we, illegal_op;
  integer     n_fail = 0, compares = 0, cycles = 0;
  aamo_core DUT (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .prog_addr(prog_addr),
    .prog_data(prog_data), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we), .acc_out(acc_out),
    .status_out(status_out), .illegal_op(illegal_op));
  aamo_fmem FM (.clk(clk), .clk_en(clk_en), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one word, then compare acc, status and the write strobe
  task ex(input [13:0] w, input [7:0] ea, es, input we, input [7:0] wd);
    begin
      @(posedge clk) prog_data <= w;
      @(posedge clk) prog_data <= 14'h0000;
      @(posedge clk) #1;
      chk({acc_out, status_out}, {ea, es});
      chk({7'h00, file_we, file_we ? file_wdata : 8'h00}, {7'h00, we, wd});
    end
  endtask
  task t_lit;
    begin
      ex(14'h3e01, 8'h01, 8'h00, 1'b0, 8'h00);
      ex(14'h3fff, 8'h00, 8'h07, 1'b0, 8'h00);
    end
  endtask
  task t_andmov;
    begin
      ex(14'h0820, 8'h0f, 8'h03, 1'b0, 8'h00);
      ex(14'h395f, 8'h0f, 8'h03, 1'b0, 8'h00);
      ex(14'h39f0, 8'h00, 8'h07, 1'b0, 8'h00);
    end
  endtask
  task t_store;
    ex(14'h00a3, 8'h00, 8'h07, 1'b1, 8'h00);
  endtask
  task t_file;
    begin
      ex(14'h3e81, 8'h81, 8'h00, 1'b0, 8'h00);
      ex(14'h0721, 8'h71, 8'h01, 1'b0, 8'h00);
      ex(14'h07a0, 8'h71, 8'h02, 1'b1, 8'h80);
      ex(14'h05a1, 8'h71, 8'h02, 1'b1, 8'h70);
      ex(14'h0522, 8'h00, 8'h06, 1'b0, 8'h00);
    end
  endtask
  task t_back;
    begin
      ex(14'h08a0, 8'h00, 8'h02, 1'b1, 8'h80);
      ex(14'h08a2, 8'h00, 8'h06, 1'b1, 8'h00);
      ex(14'h0821, 8'h70, 8'h02, 1'b0, 8'h00);
    end
  endtask
  task t_idle;
    begin
      ex(14'h0060, 8'h70, 8'h02, 1'b0, 8'h00);
      chk({15'h0000, illegal_op}, 16'h0000);
    end
  endtask
  // word outside the slice: flagged, otherwise idle
  task t_other;
    begin
      ex(14'h0062, 8'h70, 8'h02, 1'b0, 8'h00);
      chk({15'h0000, illegal_op}, 16'h0001);
    end
  endtask
  // two words back to back, one result per cycle
  task t_stream;
    begin
      @(posedge clk) prog_data <= 14'h3e01;
      @(posedge clk) prog_data <= 14'h3e02;
      @(posedge clk) prog_data <= 14'h0000;
      #1 chk({8'h00, acc_out}, 16'h0071);
      @(posedge clk) #1 chk({8'h00, acc_out}, 16'h0073);
    end
  endtask
  // enable low for one edge while an add waits in the pipeline
  task t_hold;
    begin
      @(posedge clk) prog_data <= 14'h3e01;
      @(posedge clk) clk_en <= 1'b0;
      prog_data <= 14'h0000;
      @(posedge clk) clk_en <= 1'b1;
      #1 chk({8'h00, acc_out}, 16'h0073);
      @(posedge clk) #1 chk({acc_out, status_out}, 16'h7400);
    end
  endtask
  // mid-run reset clears state, then execution restarts
  task t_reset;
    begin
      @(posedge clk) reset_n <= 1'b0;
      #1 chk({acc_out, status_out}, 16'h0000);
      chk({3'h0, prog_addr}, 16'h0000);
      @(posedge clk) reset_n <= 1'b1;
      ex(14'h3e05, 8'h05, 8'h00, 1'b0, 8'h00);
    end
  endtask
  task stop_test;
    begin
      if (n_fail == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // hang guard, far beyond the 64 or so cycles needed
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 1000)
    begin
      n_fail = n_fail + 1;
      stop_test;
    end
  end
  initial
  begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    prog_data = 14'h0000;
    #1 FM.mem[32] = 8'h0f;
    FM.mem[33] = 8'hf0;
    FM.mem[35] = 8'h5a;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_lit;
    t_andmov;
    t_store;
    t_file;
    t_back;
    t_idle;
    t_other;
    t_stream;
    t_hold;
    t_reset;
    stop_test;
  end
endmodule // testbench
